// >>> rtl/gear_gate_params.svh
// Constants for the gearing and enable gate block
// What this block, its software and its operator do
// RULE_01: In position mode, advance motor target a fixed distance per master pulse.
// RULE_02: Travel per master pulse set by programmed motor-to-master count ratio.
// RULE_03: Software computes ratio as motor PPR over master PPR times gear ratio.
// RULE_04: Enable switch function selects run behaviour or inhibit behaviour.
// RULE_05: Run behaviour, no program running: asserted input enables output stage.
// RULE_06: Run behaviour with program running acts exactly like inhibit behaviour.
// RULE_07: Inhibit behaviour: asserting input alone never enables output stage.
// RULE_08: Inhibit behaviour: program or host enable accepted only while input asserted.
// RULE_09: Enable request while input deasserted is refused and raises fault 36.
// RULE_10: Input dropping while enabled disables stage at once and raises fault 36.
// RULE_11: Torque uses no gains; velocity uses velocity gains; position uses all.
// RULE_12: Operator keeps stage disabled through the input before any tuning.
// RULE_13: Input is synchronised and filtered before enable and fault decisions.
`ifndef GEAR_GATE_PARAMS_SVH
`define GEAR_GATE_PARAMS_SVH
`define ADDR_CTRL      4'h0
`define ADDR_RATIO_NUM 4'h1
`define ADDR_RATIO_DEN 4'h2
`define ADDR_STATUS    4'h3
`define ADDR_IRQ_STAT  4'h4
`define ADDR_IRQ_MASK  4'h5
`define ADDR_POS       4'h6
`define ADDR_FAULT     4'h7
`define CTRL_MODE_LO   0
`define CTRL_MODE_HI   1
`define CTRL_FUNC_BIT  2
`define CTRL_PROG_BIT  3
`define CTRL_EN_BIT    4
`define CTRL_DIS_BIT   5
`define FAULT_ENABLE   8'h24
`define FILT_TIME_NS   1000
`define CLK_PERIOD_NS  10
`define FILT_CYCLES    (`FILT_TIME_NS / `CLK_PERIOD_NS)
`define IRQ_FAULT_BIT  0
`define IRQ_REFUSE_BIT 1
`define IRQ_INPUT_BIT  2
`endif

// >>> rtl/gear_gate_pkg.sv
// Types shared by the gearing and enable gate block
package gear_gate_pkg;
    typedef enum logic [1:0] {MODE_TORQUE, MODE_VELOCITY, MODE_POSITION} drive_mode_t;
    typedef enum logic {FUNC_RUN, FUNC_INHIBIT} enable_func_t;
    typedef enum {ST_DISABLED, ST_ENABLED} gate_state_t;
    typedef struct packed {
        logic vel_gains;   // Velocity P, I and gain scaling
        logic pos_gains;   // Position P, I, D and integral limit
    } gain_use_t;
endpackage : gear_gate_pkg

// >>> rtl/servo_gear_gate.sv
// Electronic gearing and enable/inhibit gate with Avalon-MM registers
`timescale 1ns/1ns
`include "gear_gate_params.svh"
module servo_gear_gate import gear_gate_pkg::*; (
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        MASTER_PULSE,
    input  wire logic        MASTER_DIR,
    input  wire logic        ENABLE_INHIBIT_INPUT,
    output logic             STAGE_ENABLE,
    output logic      [31:0] MOTOR_TARGET,
    output logic             VEL_GAINS_USED,
    output logic             POS_GAINS_USED,
    output logic             IRQ
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [31:0]  rdata_q;
    logic         wait_q;
    logic [1:0]   mode_q;
    logic         func_q;
    logic         prog_q;
    logic [15:0]  ratio_num_q;
    logic [15:0]  ratio_den_q;
    logic [2:0]   irq_stat_q;
    logic [2:0]   irq_mask_q;
    logic [7:0]   fault_q;
    logic         en_req;
    logic         dis_req;
    logic         wr_acc;
    logic         rd_acc;
    logic         in_ok;
    logic [31:0]  target_q;
    logic [2:0]   ev;
    gate_state_t  state_q;
    drive_mode_t  mode;
    enable_func_t func;
    gain_use_t    gains_d;

    assign mode = drive_mode_t'(mode_q);
    assign func = enable_func_t'(func_q);

    // One wait cycle per access keeps read data registered; a write lands
    // only at the edge where the master sees waitrequest low
    assign wr_acc = AVS_WRITE && !wait_q;
    assign rd_acc = AVS_READ && wait_q;
    assign en_req = wr_acc && AVS_ADDRESS == `ADDR_CTRL && AVS_WRITEDATA[`CTRL_EN_BIT];
    assign dis_req = wr_acc && AVS_ADDRESS == `ADDR_CTRL && AVS_WRITEDATA[`CTRL_DIS_BIT];

    // Waitrequest drops for one cycle after each request is seen
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wait_q <= 1'b1;
        end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Configuration writes; ratio is precomputed by software [RULE_03]
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_q      <= 2'h0;
            func_q      <= 1'b0;
            prog_q      <= 1'b0;
            ratio_num_q <= 16'h0001;
            ratio_den_q <= 16'h0001;
            irq_mask_q  <= 3'h0;
        end else if (wr_acc) begin
            unique case (AVS_ADDRESS)
                `ADDR_CTRL: begin
                    mode_q <= AVS_WRITEDATA[`CTRL_MODE_HI:`CTRL_MODE_LO];
                    func_q <= AVS_WRITEDATA[`CTRL_FUNC_BIT]; // [RULE_04]
                    prog_q <= AVS_WRITEDATA[`CTRL_PROG_BIT];
                end
                `ADDR_RATIO_NUM: ratio_num_q <= AVS_WRITEDATA[15:0]; // [RULE_02]
                `ADDR_RATIO_DEN: ratio_den_q <= AVS_WRITEDATA[15:0];
                `ADDR_IRQ_MASK:  irq_mask_q  <= AVS_WRITEDATA[2:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= 32'h0;
        end else if (rd_acc) begin
            unique case (AVS_ADDRESS)
                `ADDR_CTRL:      rdata_q <= {28'h0, prog_q, func_q, mode_q};
                `ADDR_RATIO_NUM: rdata_q <= {16'h0, ratio_num_q};
                `ADDR_RATIO_DEN: rdata_q <= {16'h0, ratio_den_q};
                `ADDR_STATUS:    rdata_q <= {30'h0, in_ok, state_q == ST_ENABLED};
                `ADDR_IRQ_STAT:  rdata_q <= {29'h0, irq_stat_q};
                `ADDR_IRQ_MASK:  rdata_q <= {29'h0, irq_mask_q};
                `ADDR_POS:       rdata_q <= target_q;
                `ADDR_FAULT:     rdata_q <= {24'h0, fault_q};
                default:         rdata_q <= 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // Input conditioning
    // ****************************************************************
    logic        sync1_q;
    logic        sync2_q;
    logic [7:0]  filt_cnt_q;
    logic        in_ok_q;

    // Two-stage synchroniser [RULE_13]
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= ENABLE_INHIBIT_INPUT;
            sync2_q <= sync1_q;
        end
    end

    // Level must hold for the filter time before it is believed [RULE_13]
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            filt_cnt_q <= 8'h0;
            in_ok_q    <= 1'b0;
        end else if (sync2_q == in_ok_q) begin
            filt_cnt_q <= 8'h0;
        end else if (filt_cnt_q == 8'(`FILT_CYCLES - 1)) begin
            filt_cnt_q <= 8'h0;
            in_ok_q    <= sync2_q;
        end else begin
            filt_cnt_q <= filt_cnt_q + 8'h1;
        end
    end
    assign in_ok = in_ok_q;

    // ****************************************************************
    // Enable gate
    // ****************************************************************
    logic in_rise;
    logic in_prev_q;
    logic run_auto;
    logic drop;
    logic refuse;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            in_prev_q <= 1'b0;
        end else begin
            in_prev_q <= in_ok;
        end
    end
    assign in_rise = in_ok && !in_prev_q;
    // Run without program: input is a plain enable; otherwise inhibit rules [RULE_05] [RULE_06]
    assign run_auto = func == FUNC_RUN && !prog_q;
    assign drop     = state_q == ST_ENABLED && !in_ok;               // [RULE_10]
    assign refuse   = en_req && !in_ok;                              // [RULE_09]

    // Gate state; a drop always wins over any request [RULE_07] [RULE_08]
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_DISABLED;
        end else begin
            unique case (state_q)
                ST_DISABLED: begin
                    if (in_ok && ((run_auto && in_rise) || en_req)) begin
                        state_q <= ST_ENABLED;
                    end
                end
                ST_ENABLED: begin
                    if (!in_ok || dis_req) begin
                        state_q <= ST_DISABLED; // [RULE_10]
                    end
                end
            endcase
        end
    end

    // Fault code holds until the next accepted host enable request; an input-driven run enable leaves it set
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            fault_q <= 8'h0;
        end else if (drop || refuse) begin
            fault_q <= `FAULT_ENABLE; // [RULE_09] [RULE_10]
        end else if (en_req) begin
            fault_q <= 8'h0;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    assign ev = {in_ok != in_prev_q, refuse, drop || refuse};

    // Write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_stat_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ev[i]) begin
                    irq_stat_q[i] <= 1'b1;
                end else if (wr_acc && AVS_ADDRESS == `ADDR_IRQ_STAT && AVS_WRITEDATA[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Gearing
    // ****************************************************************
    logic [15:0] acc_q;
    logic        pulse_prev_q;
    logic        pulse_edge;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pulse_prev_q <= 1'b0;
        end else begin
            pulse_prev_q <= MASTER_PULSE;
        end
    end
    assign pulse_edge = MASTER_PULSE && !pulse_prev_q;

    // Each master pulse in position mode while enabled moves the target num/den counts; remainder kept [RULE_01] [RULE_02]
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            target_q <= 32'h0;
            acc_q    <= 16'h0;
        end else if (pulse_edge && mode == MODE_POSITION && state_q == ST_ENABLED
                     && ratio_den_q != 16'h0) begin
            acc_q <= 16'(({16'h0, acc_q} + {16'h0, ratio_num_q}) % {16'h0, ratio_den_q});
            if (MASTER_DIR) begin
                target_q <= target_q - 32'(({16'h0, acc_q} + {16'h0, ratio_num_q})
                                           / {16'h0, ratio_den_q});
            end else begin
                target_q <= target_q + 32'(({16'h0, acc_q} + {16'h0, ratio_num_q})
                                           / {16'h0, ratio_den_q});
            end
        end
    end

    // Gain sets in use per mode [RULE_11]
    always_comb begin
        gains_d = '{vel_gains: 1'b0, pos_gains: 1'b0};
        unique case (mode)
            MODE_VELOCITY: gains_d.vel_gains = 1'b1;
            MODE_POSITION: gains_d = '{vel_gains: 1'b1, pos_gains: 1'b1};
            default: ;
        endcase
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            STAGE_ENABLE   <= 1'b0;
            MOTOR_TARGET   <= 32'h0;
            VEL_GAINS_USED <= 1'b0;
            POS_GAINS_USED <= 1'b0;
            IRQ            <= 1'b0;
        end else begin
            STAGE_ENABLE   <= state_q == ST_ENABLED && in_ok; // [RULE_10]
            MOTOR_TARGET   <= target_q;
            VEL_GAINS_USED <= gains_d.vel_gains;
            POS_GAINS_USED <= gains_d.pos_gains;
            IRQ            <= |(irq_stat_q & irq_mask_q);
        end
    end
    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_refuse_fault: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE_09]
        refuse |=> fault_q == `FAULT_ENABLE && state_q == ST_DISABLED)
        else $error("refused enable did not raise fault");
    chk_drop_disable: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE_10]
        drop |=> state_q == ST_DISABLED ##1 !STAGE_ENABLE)
        else $error("input loss did not disable stage");
    chk_inhibit_noauto: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE_07]
        (state_q == ST_DISABLED && !run_auto && !en_req) |=> state_q == ST_DISABLED)
        else $error("input enabled stage under inhibit");
    chk_run_auto: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE_05]
        (state_q == ST_DISABLED && run_auto && in_rise) |=> state_q == ST_ENABLED)
        else $error("run input did not enable");
    chk_accept_req: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE_08]
        (en_req && in_ok) |=> state_q == ST_ENABLED)
        else $error("valid enable request dropped");
    chk_filter_hold: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE_13]
        $changed(in_ok_q) |-> $past(sync2_q) == in_ok_q && filt_cnt_q == 8'h0)
        else $error("filter passed unsettled input");
    chk_gear_step: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE_01]
        (mode != MODE_POSITION || state_q != ST_ENABLED) |=> $stable(target_q))
        else $error("target moved outside position mode");
    chk_gain_sets: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE_11]
        mode == MODE_TORQUE |=> !VEL_GAINS_USED && !POS_GAINS_USED)
        else $error("gains used in torque mode");
    chk_run_prog: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE_06]
        (state_q == ST_DISABLED && func == FUNC_RUN && prog_q && !en_req)
        |=> state_q == ST_DISABLED)
        else $error("run with program not inhibit-like");

endmodule : servo_gear_gate

// >>> tb/enc_switch_model.sv
// Far-side model: master encoder pulse source and external enable switch
`timescale 1ns/1ns
module enc_switch_model (
    input  wire logic clk,
    output logic      pulse,
    output logic      dir,
    output logic      sw
);
    // Switch open and pulse line low at power-up, so the stage stays off
    initial begin
        pulse = 1'b0;
        dir   = 1'b0;
        sw    = 1'b0;
    end

    // One count per rising edge, two cycles per count
    task automatic send_pulses(input int n, input logic d);
        repeat (n) begin
            @(posedge clk);
            pulse <= 1'b1;
            dir   <= d;
            @(posedge clk);
            pulse <= 1'b0;
        end
    endtask : send_pulses

    // Switch moves only after a clock edge
    task automatic set_switch(input logic v);
        @(posedge clk);
        sw <= v;
    endtask : set_switch

    // Contact bounce shorter than the filter time
    task automatic bounce(input int w);
        @(posedge clk);
        sw <= 1'b1;
        repeat (w) @(posedge clk);
        sw <= 1'b0;
    endtask : bounce
endmodule : enc_switch_model

// >>> tb/servo_gear_gate_tb.sv
// Self-checking bench for the gearing and enable gate block
`timescale 1ns/1ns
`include "gear_gate_params.svh"
module servo_gear_gate_tb import gear_gate_pkg::*;;
    logic        clk, rst_b, rd, wr, wait_req, pulse, dir, sw, stage_en, vel_g, pos_g, irq;
    logic [3:0]  adr;
    logic [31:0] wdata, rdata, target;
    int          mismatches, checks_done;
    logic [1:0]  gain_exp [3] = '{2'b00, 2'b10, 2'b11};

    servo_gear_gate DUT (.CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .MASTER_PULSE(pulse), .MASTER_DIR(dir),
        .ENABLE_INHIBIT_INPUT(sw), .STAGE_ENABLE(stage_en), .MOTOR_TARGET(target),
        .VEL_GAINS_USED(vel_g), .POS_GAINS_USED(pos_g), .IRQ(irq));
    enc_switch_model far (.clk(clk), .pulse(pulse), .dir(dir), .sw(sw));

    // ****************************************
    // Clock, reset and bus tasks
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        adr   <= a;
        wr    <= w;
        rd    <= ~w;
        wdata <= d;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        chk({31'h0, wait_req}, 32'h0, "bus answer");
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(q, exp, what);
    endtask : rd_chk

    function automatic logic [31:0] ctrl(input logic [1:0] m, input logic f, p, e, x);
        return {26'h0, x, e, p, f, m};
    endfunction : ctrl

    // Filter plus synchroniser is about 103 cycles; leave margin
    task automatic settle();
        repeat (`FILT_CYCLES + 20) @(posedge clk);
    endtask : settle

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Hang guard: the whole sequence needs about 1040 cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 4'h0;
        wdata = 32'h0;
        mismatches = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        chk({31'h0, wait_req}, 32'h1, "waitrequest in reset");
        rst_b <= 1'b1;
        rd_chk(`ADDR_RATIO_NUM, 32'h1, "num reset");
        rd_chk(`ADDR_RATIO_DEN, 32'h1, "den reset");
        rd_chk(`ADDR_STATUS, 32'h0, "status reset");
        wr_reg(4'h9, 32'hffffffff);
        rd_chk(4'h9, 32'h0, "unmapped");
        $display("test reset done");
        for (int m = 0; m < 3; m++) begin
            wr_reg(`ADDR_CTRL, ctrl(m[1:0], 1'b1, 1'b0, 1'b0, 1'b0));
            repeat (3) @(posedge clk);
            chk({30'h0, vel_g, pos_g}, {30'h0, gain_exp[m]}, "gain sets");
        end
        $display("test gains done");
        wr_reg(`ADDR_IRQ_MASK, 32'h0);
        wr_reg(`ADDR_CTRL, ctrl(2'd2, 1'b1, 1'b0, 1'b1, 1'b0));
        rd_chk(`ADDR_FAULT, 32'h24, "refused enable fault");
        rd_chk(`ADDR_IRQ_STAT, 32'h3, "refuse events");
        chk({30'h0, stage_en, irq}, 32'h0, "refused stays off, irq masked");
        wr_reg(`ADDR_IRQ_MASK, 32'h3);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr_reg(`ADDR_IRQ_STAT, 32'h3);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("test refuse done");
        far.bounce(20);
        settle();
        rd_chk(`ADDR_STATUS, 32'h0, "bounce filtered");
        far.set_switch(1'b1);
        settle();
        rd_chk(`ADDR_STATUS, 32'h2, "inhibit input alone");
        chk({31'h0, stage_en}, 32'h0, "inhibit stage off");
        wr_reg(`ADDR_CTRL, ctrl(2'd2, 1'b1, 1'b0, 1'b1, 1'b0));
        rd_chk(`ADDR_STATUS, 32'h3, "enable accepted");
        rd_chk(`ADDR_FAULT, 32'h0, "fault cleared");
        chk({31'h0, stage_en}, 32'h1, "stage on");
        $display("test inhibit done");
        // Ratio = motor counts per rev / master counts per rev x gear: 4000/1000 x 3
        wr_reg(`ADDR_RATIO_NUM, 32'hc);
        far.send_pulses(5, 1'b0);
        repeat (4) @(posedge clk);
        chk(target, 32'h3c, "5 pulses at 12:1");
        wr_reg(`ADDR_RATIO_NUM, 32'h3);
        wr_reg(`ADDR_RATIO_DEN, 32'h4);
        far.send_pulses(4, 1'b0);
        repeat (4) @(posedge clk);
        rd_chk(`ADDR_POS, 32'h3f, "4 pulses at 3:4");
        wr_reg(`ADDR_RATIO_NUM, 32'hc);
        wr_reg(`ADDR_RATIO_DEN, 32'h1);
        far.send_pulses(2, 1'b1);
        repeat (4) @(posedge clk);
        chk(target, 32'h27, "2 pulses down");
        wr_reg(`ADDR_CTRL, ctrl(2'd1, 1'b1, 1'b0, 1'b0, 1'b0));
        far.send_pulses(3, 1'b0);
        repeat (4) @(posedge clk);
        chk(target, 32'h27, "no gearing in velocity mode");
        $display("test gearing done");
        far.set_switch(1'b0);
        settle();
        chk({31'h0, stage_en}, 32'h0, "input loss disables");
        rd_chk(`ADDR_FAULT, 32'h24, "input loss fault");
        rd_chk(`ADDR_IRQ_STAT, 32'h5, "input loss events");
        $display("test input loss done");
        wr_reg(`ADDR_CTRL, ctrl(2'd2, 1'b0, 1'b0, 1'b0, 1'b0));
        far.set_switch(1'b1);
        settle();
        chk({31'h0, stage_en}, 32'h1, "run input enables");
        far.set_switch(1'b0);
        settle();
        chk({31'h0, stage_en}, 32'h0, "run input loss");
        wr_reg(`ADDR_CTRL, ctrl(2'd2, 1'b0, 1'b1, 1'b0, 1'b0));
        far.set_switch(1'b1);
        settle();
        chk({31'h0, stage_en}, 32'h0, "run with program acts as inhibit");
        wr_reg(`ADDR_CTRL, ctrl(2'd2, 1'b0, 1'b1, 1'b1, 1'b0));
        repeat (3) @(posedge clk);
        chk({31'h0, stage_en}, 32'h1, "program enable");
        wr_reg(`ADDR_CTRL, ctrl(2'd2, 1'b0, 1'b1, 1'b0, 1'b1));
        repeat (3) @(posedge clk);
        chk({31'h0, stage_en}, 32'h0, "disable request");
        $display("test run done");
        // Reset in mid-run with the switch closed: everything starts over
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, wait_req}, 32'h1, "waitrequest in mid reset");
        rst_b <= 1'b1;
        rd_chk(`ADDR_STATUS, 32'h0, "status after mid reset");
        rd_chk(`ADDR_RATIO_NUM, 32'h1, "num after mid reset");
        chk(target, 32'h0, "target after mid reset");
        chk({31'h0, stage_en}, 32'h0, "stage off after mid reset");
        settle();
        chk({31'h0, stage_en}, 32'h1, "run input enables after reset");
        $display("test mid reset done");
        give_verdict();
    end
endmodule : servo_gear_gate_tb
